// >>> common/sws_regs.svh
/*
 Constants for the single-wire slave: timing figures, address limits,
 command framing bytes and CRC polynomials.
 Assumes a 200 MHz system clock; included by the slave and its CRC unit.
*/
// How it works
// [R1] master opens read slot like write-one
// [R2] zero bit: device pulls low, own release
// [R3] one bit: device never pulls line low
// [R4] master samples late inside its window
// [R5] master waits full slot before next
// [R6] extra start-edge filter only at standard speed
// [R7] lows inside rising-edge holdoff are ignored
// [R8] identifier top byte is CRC8 of 56
// [R9] CRC16 always sent ones-complemented
// [R10] register read CRC: cmd, address, data
// [R11] first channel read CRC includes command
// [R12] later channel passes CRC only samples
// [R13] channel read loops samples plus CRC
// [R14] master sends address low byte first
// [R15] finished or failed command returns FF
// [R16] activity latch clear then AA forever
// [R17] write pair: second is inverse, apply
// [R18] valid write answers AA then pins
// [R19] mismatched write pair leaves port unchanged
// [R20] long reset returns to standard speed
// [R21] CRC shifted least significant bit first
`ifndef SWS_REGS_SVH
`define SWS_REGS_SVH

`define SWS_CLK_PERIOD_NS 5
`define SWS_SAMPLE_STD_NS 30000
`define SWS_SAMPLE_OD_NS 3000
`define SWS_HOLD0_STD_NS 30000
`define SWS_HOLD0_OD_NS 3000
`define SWS_FILTER_STD_NS 250
`define SWS_HOLDOFF_STD_NS 2000
`define SWS_HOLDOFF_OD_NS 500
`define SWS_RESET_LONG_NS 480000
`define SWS_RESET_OD_NS 48000

`define SWS_PAGE_FIRST 16'h0088
`define SWS_PAGE_LAST 16'h008F
`define SWS_CS_FIRST 16'h008B
`define SWS_CS_LAST 16'h008D
`define SWS_CONFIRM_BYTE 8'hAA
`define SWS_FILL_BYTE 8'hFF
`define SWS_CAR_SAMPLES 32

`define SWS_CRC16_POLY_REFL 16'hA001
`define SWS_CRC8_POLY_REFL 8'h8C

`endif

// >>> common/sws_pkg.sv
/*
 Types of the single-wire slave: slot timing states and frame states.
 Assumes nothing of its surroundings.
*/
package sws_pkg;

	typedef enum logic [1:0] {
		SL_HOLD,
		SL_IDLE,
		SL_FILT,
		SL_ACTIVE
	} sws_slot_type;

	typedef enum logic [3:0] {
		FR_IDLE,
		FR_CMD,
		FR_ADDR_LO,
		FR_ADDR_HI,
		FR_RD_DATA,
		FR_CRC_LO,
		FR_CRC_HI,
		FR_CAR_DATA,
		FR_CAW_A,
		FR_CAW_B,
		FR_CAW_ACK,
		FR_CAW_RB,
		FR_CS_DATA,
		FR_FILL_FF,
		FR_FILL_AA
	} sws_frame_type;

endpackage

// >>> logic/sws_crc16.sv
/*
 Serial CRC16 generator, reflected form, one bit per shift strobe.
 Assumes an active-low reset released in step with sys_clk, one bit per strobe at most.
*/
`timescale 1ns/1ps
`include "sws_regs.svh"

module sws_crc16 (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic crc_clear,
	input wire logic crc_shift,
	input wire logic crc_bit,
	output logic [15:0] crc_value
);

	logic [15:0] crc_reg;
	logic feedback;

	assign feedback = crc_bit ^ crc_reg[0];
	assign crc_value = crc_reg;

	// clear beats shift: the cleared state is the start of a new pass
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			crc_reg <= 16'h0000;
		end else if (crc_clear) begin
			crc_reg <= 16'h0000;
		end else if (crc_shift) begin
			crc_reg <= (crc_reg >> 1) ^ (feedback ? `SWS_CRC16_POLY_REFL : 16'h0000); // [R21]
		end
	end

endmodule

// >>> logic/sws_slave.sv
/*
 Single-wire slave: slot timing, glitch filtering, byte framing of the
 control-function commands and CRC generation.
 Assumes the ROM selection layer sits outside and pulses set_fast; line_in
 is already synchronous to sys_clk; line_oe low lets the pull-up raise it.
*/
`timescale 1ns/1ps
`include "sws_regs.svh"

module sws_slave #(
	parameter int SAMP_STD_CYC = (`SWS_SAMPLE_STD_NS + `SWS_CLK_PERIOD_NS - 1) / `SWS_CLK_PERIOD_NS,
	parameter int SAMP_OD_CYC = (`SWS_SAMPLE_OD_NS + `SWS_CLK_PERIOD_NS - 1) / `SWS_CLK_PERIOD_NS,
	parameter int HOLD_STD_CYC = `SWS_HOLD0_STD_NS / `SWS_CLK_PERIOD_NS,
	parameter int HOLD_OD_CYC = `SWS_HOLD0_OD_NS / `SWS_CLK_PERIOD_NS,
	parameter int RST_LONG_CYC = (`SWS_RESET_LONG_NS + `SWS_CLK_PERIOD_NS - 1) / `SWS_CLK_PERIOD_NS,
	parameter int RST_OD_CYC = (`SWS_RESET_OD_NS + `SWS_CLK_PERIOD_NS - 1) / `SWS_CLK_PERIOD_NS,
	parameter logic [7:0] CMD_REG_READ = 8'h01,
	parameter logic [7:0] CMD_CH_READ = 8'h02,
	parameter logic [7:0] CMD_CH_WRITE = 8'h03,
	parameter logic [7:0] CMD_CS_WRITE = 8'h04,
	parameter logic [7:0] CMD_LATCH_CLEAR = 8'h05,
	// arbitrary identifier body
	parameter logic [55:0] ROM_BODY = 56'h00000000000001
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic line_in,
	output logic line_out,
	output logic line_oe,
	input wire logic set_fast,
	input wire logic [7:0] port_pins,
	input wire logic [63:0] reg_page,
	output logic fast_speed_flag,
	output logic [7:0] port_state,
	output logic latch_clear,
	output logic cs_wr_strobe,
	output logic [7:0] cs_wr_addr,
	output logic [7:0] cs_wr_data,
	output logic session_start,
	output logic [63:0] rom_code
);

	localparam int CW = 18;
	localparam int FILT_CYC = (`SWS_FILTER_STD_NS + `SWS_CLK_PERIOD_NS - 1) / `SWS_CLK_PERIOD_NS;
	localparam int REH_STD_CYC = `SWS_HOLDOFF_STD_NS / `SWS_CLK_PERIOD_NS;
	localparam int REH_OD_CYC = `SWS_HOLDOFF_OD_NS / `SWS_CLK_PERIOD_NS;
	localparam logic [CW-1:0] CNT_MAX = {CW{1'b1}};
	localparam logic [4:0] CAR_LAST = 5'(`SWS_CAR_SAMPLES - 1);

	function automatic logic [7:0] page_byte(input logic [63:0] page, input logic [15:0] addr);
		page_byte = page[addr[2:0] * 8 +: 8];
	endfunction

	function automatic logic is_tx(input sws_pkg::sws_frame_type st);
		is_tx = (st == sws_pkg::FR_RD_DATA) || (st == sws_pkg::FR_CRC_LO) ||
			(st == sws_pkg::FR_CRC_HI) || (st == sws_pkg::FR_CAR_DATA) ||
			(st == sws_pkg::FR_CAW_ACK) || (st == sws_pkg::FR_CAW_RB) ||
			(st == sws_pkg::FR_FILL_FF) || (st == sws_pkg::FR_FILL_AA);
	endfunction

	function automatic logic [7:0] crc8_of(input logic [55:0] body);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++) begin
			c = (c >> 1) ^ ((c[0] ^ body[i]) ? `SWS_CRC8_POLY_REFL : 8'h00);
		end
		crc8_of = c;
	endfunction

	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_n;

	sws_pkg::sws_slot_type slot_reg;
	logic [CW-1:0] slot_cnt_reg;
	logic [CW-1:0] low_cnt_reg;
	logic bit_evt_reg;
	logic bit_val_reg;
	logic reset_evt_reg;
	logic long_reset_reg;
	logic drive_reg;
	logic line_oe_reg;
	logic fast_reg;
	logic [63:0] rom_code_reg;

	sws_pkg::sws_frame_type frame_reg;
	logic [2:0] bit_cnt_reg;
	logic [7:0] rx_byte_reg;
	logic [7:0] tx_byte_reg;
	logic [7:0] cmd_reg;
	logic [15:0] addr_reg;
	logic [4:0] sample_idx_reg;
	logic [7:0] first_reg;
	logic [7:0] port_state_reg;
	logic latch_clear_reg;
	logic cs_wr_strobe_reg;
	logic [7:0] cs_wr_addr_reg;
	logic [7:0] cs_wr_data_reg;
	logic session_reg;

	logic [CW-1:0] samp_cyc;
	logic [CW-1:0] hold_cyc;
	logic [CW-1:0] reh_cyc;
	logic [CW-1:0] rst_min_cyc;
	logic tx_bit;
	logic tx_active;
	logic [7:0] rx_full;
	logic byte_done;
	logic crc_clear;
	logic crc_shift;
	logic crc_bit;
	logic [15:0] crc_value;
	logic [15:0] crc_inv;
	logic [15:0] addr_full;

	assign rst_n = rst_sync_reg;
	assign line_out = 1'b0;
	assign line_oe = line_oe_reg;
	assign fast_speed_flag = fast_reg;
	assign port_state = port_state_reg;
	assign latch_clear = latch_clear_reg;
	assign cs_wr_strobe = cs_wr_strobe_reg;
	assign cs_wr_addr = cs_wr_addr_reg;
	assign cs_wr_data = cs_wr_data_reg;
	assign session_start = session_reg;
	assign rom_code = rom_code_reg;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign samp_cyc = fast_reg ? CW'(SAMP_OD_CYC) : CW'(SAMP_STD_CYC);
	assign hold_cyc = fast_reg ? CW'(HOLD_OD_CYC) : CW'(HOLD_STD_CYC);
	assign reh_cyc = fast_reg ? CW'(REH_OD_CYC) : CW'(REH_STD_CYC);
	assign rst_min_cyc = fast_reg ? CW'(RST_OD_CYC) : CW'(RST_LONG_CYC);

	// identifier with its check byte on top, non-inverted
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rom_code_reg <= 64'h0000000000000000;
		end else begin
			rom_code_reg <= {crc8_of(ROM_BODY), ROM_BODY}; // [R8]
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt_reg <= '0;
		end else if (line_in) begin
			low_cnt_reg <= '0;
		end else if (low_cnt_reg != CNT_MAX) begin
			low_cnt_reg <= low_cnt_reg + CW'(1);
		end
	end

	// slot time base, restarted at every accepted falling edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_reg <= sws_pkg::SL_HOLD;
			slot_cnt_reg <= '0;
			bit_evt_reg <= 1'b0;
			bit_val_reg <= 1'b1;
			reset_evt_reg <= 1'b0;
			long_reset_reg <= 1'b0;
			drive_reg <= 1'b0;
		end else begin
			bit_evt_reg <= 1'b0;
			reset_evt_reg <= 1'b0;
			unique case (slot_reg)
				sws_pkg::SL_HOLD: begin
					// lows here are ringing after the rise, not a slot
					if (slot_cnt_reg >= reh_cyc) begin // [R7]
						slot_reg <= sws_pkg::SL_IDLE;
						slot_cnt_reg <= '0;
					end else begin
						slot_cnt_reg <= slot_cnt_reg + CW'(1);
					end
				end
				sws_pkg::SL_IDLE: begin
					if (!line_in) begin
						drive_reg <= tx_active && !tx_bit; // [R2] [R3]
						if (fast_reg) begin // [R6]
							slot_reg <= sws_pkg::SL_ACTIVE;
							slot_cnt_reg <= '0;
						end else begin
							slot_reg <= sws_pkg::SL_FILT;
							slot_cnt_reg <= '0;
						end
					end
				end
				sws_pkg::SL_FILT: begin
					if (line_in) begin
						slot_reg <= sws_pkg::SL_IDLE; // [R6]
						drive_reg <= 1'b0;
					end else if (slot_cnt_reg >= CW'(FILT_CYC - 1)) begin
						slot_reg <= sws_pkg::SL_ACTIVE;
						slot_cnt_reg <= CW'(FILT_CYC);
					end else begin
						slot_cnt_reg <= slot_cnt_reg + CW'(1);
					end
				end
				sws_pkg::SL_ACTIVE: begin
					if (slot_cnt_reg != CNT_MAX) begin
						slot_cnt_reg <= slot_cnt_reg + CW'(1);
					end
					if (slot_cnt_reg == samp_cyc) begin
						bit_evt_reg <= 1'b1;
						bit_val_reg <= line_in;
					end
					if (line_in && slot_cnt_reg > samp_cyc) begin
						slot_reg <= sws_pkg::SL_HOLD;
						slot_cnt_reg <= '0;
						drive_reg <= 1'b0;
						if (low_cnt_reg >= rst_min_cyc) begin
							reset_evt_reg <= 1'b1;
							long_reset_reg <= low_cnt_reg >= CW'(RST_LONG_CYC);
						end
					end
				end
			endcase
		end
	end

	// zero bit: pull low from slot activation (after the start filter at standard speed) until own hold time ends
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			line_oe_reg <= 1'b0;
		end else begin
			line_oe_reg <= drive_reg && (slot_reg == sws_pkg::SL_ACTIVE) &&
				(slot_cnt_reg < hold_cyc); // [R2] [R3]
		end
	end

	// a new speed request wins over a long reset in the same cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fast_reg <= 1'b0;
		end else if (set_fast) begin
			fast_reg <= 1'b1;
		end else if (reset_evt_reg && long_reset_reg) begin
			fast_reg <= 1'b0; // [R20]
		end
	end

	assign crc_inv = ~crc_value; // [R9]
	assign rx_full = {bit_val_reg, rx_byte_reg[7:1]};
	assign byte_done = bit_evt_reg && (bit_cnt_reg == 3'h7);
	assign addr_full = {rx_full, addr_reg[7:0]};
	assign tx_active = is_tx(frame_reg);

	always_comb begin
		unique case (frame_reg)
			sws_pkg::FR_CRC_LO: tx_bit = crc_inv[{1'b0, bit_cnt_reg}];
			sws_pkg::FR_CRC_HI: tx_bit = crc_inv[{1'b1, bit_cnt_reg}];
			default: tx_bit = tx_byte_reg[bit_cnt_reg];
		endcase
	end

	always_comb begin
		crc_clear = reset_evt_reg ||
			(byte_done && frame_reg == sws_pkg::FR_CRC_HI && cmd_reg == CMD_CH_READ); // [R12]
		crc_shift = bit_evt_reg && ((frame_reg == sws_pkg::FR_CMD) ||
			(frame_reg == sws_pkg::FR_ADDR_LO) || (frame_reg == sws_pkg::FR_ADDR_HI) ||
			(frame_reg == sws_pkg::FR_RD_DATA) || (frame_reg == sws_pkg::FR_CAR_DATA)); // [R10] [R11]
		crc_bit = tx_active ? tx_bit : bit_val_reg; // [R21]
	end

	sws_crc16 crc_unit (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.crc_clear(crc_clear),
		.crc_shift(crc_shift),
		.crc_bit(crc_bit),
		.crc_value(crc_value)
	);

	// byte framing; only a reset pulse leaves the fill loops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_reg <= sws_pkg::FR_IDLE;
			bit_cnt_reg <= 3'h0;
			rx_byte_reg <= 8'h00;
			tx_byte_reg <= `SWS_FILL_BYTE;
			cmd_reg <= 8'h00;
			addr_reg <= 16'h0000;
			sample_idx_reg <= 5'h00;
			first_reg <= 8'h00;
			port_state_reg <= 8'hFF;
			latch_clear_reg <= 1'b0;
			cs_wr_strobe_reg <= 1'b0;
			cs_wr_addr_reg <= 8'h00;
			cs_wr_data_reg <= 8'h00;
			session_reg <= 1'b0;
		end else begin
			latch_clear_reg <= 1'b0;
			cs_wr_strobe_reg <= 1'b0;
			session_reg <= 1'b0;
			if (reset_evt_reg) begin
				frame_reg <= sws_pkg::FR_CMD;
				bit_cnt_reg <= 3'h0;
				session_reg <= 1'b1;
			end else if (bit_evt_reg) begin
				rx_byte_reg <= rx_full;
				bit_cnt_reg <= bit_cnt_reg + 3'h1;
				if (byte_done) begin
					unique case (frame_reg)
						sws_pkg::FR_IDLE: frame_reg <= sws_pkg::FR_IDLE;
						sws_pkg::FR_CMD: begin
							cmd_reg <= rx_full;
							tx_byte_reg <= `SWS_FILL_BYTE;
							if (rx_full == CMD_REG_READ || rx_full == CMD_CS_WRITE) begin
								frame_reg <= sws_pkg::FR_ADDR_LO;
							end else if (rx_full == CMD_CH_READ) begin
								frame_reg <= sws_pkg::FR_CAR_DATA;
								sample_idx_reg <= 5'h00;
								tx_byte_reg <= port_pins;
							end else if (rx_full == CMD_CH_WRITE) begin
								frame_reg <= sws_pkg::FR_CAW_A;
							end else if (rx_full == CMD_LATCH_CLEAR) begin
								latch_clear_reg <= 1'b1;
								frame_reg <= sws_pkg::FR_FILL_AA;
								tx_byte_reg <= `SWS_CONFIRM_BYTE; // [R16]
							end else begin
								frame_reg <= sws_pkg::FR_FILL_FF;
							end
						end
						sws_pkg::FR_ADDR_LO: begin
							addr_reg[7:0] <= rx_full; // [R14]
							frame_reg <= sws_pkg::FR_ADDR_HI;
						end
						sws_pkg::FR_ADDR_HI: begin
							addr_reg <= addr_full;
							tx_byte_reg <= `SWS_FILL_BYTE;
							frame_reg <= sws_pkg::FR_FILL_FF; // [R15]
							if (cmd_reg == CMD_REG_READ && addr_full >= `SWS_PAGE_FIRST &&
								addr_full <= `SWS_PAGE_LAST) begin
								frame_reg <= sws_pkg::FR_RD_DATA;
								tx_byte_reg <= page_byte(reg_page, addr_full);
							end else if (cmd_reg == CMD_CS_WRITE && addr_full >= `SWS_CS_FIRST &&
								addr_full <= `SWS_CS_LAST) begin
								frame_reg <= sws_pkg::FR_CS_DATA;
							end
						end
						sws_pkg::FR_RD_DATA: begin
							if (addr_reg == `SWS_PAGE_LAST) begin // [R10]
								frame_reg <= sws_pkg::FR_CRC_LO;
							end else begin
								addr_reg <= addr_reg + 16'h0001;
								tx_byte_reg <= page_byte(reg_page, addr_reg + 16'h0001);
							end
						end
						sws_pkg::FR_CRC_LO: frame_reg <= sws_pkg::FR_CRC_HI;
						sws_pkg::FR_CRC_HI: begin
							if (cmd_reg == CMD_CH_READ) begin // [R13]
								frame_reg <= sws_pkg::FR_CAR_DATA;
								sample_idx_reg <= 5'h00;
								tx_byte_reg <= port_pins;
							end else begin
								frame_reg <= sws_pkg::FR_FILL_FF; // [R15]
								tx_byte_reg <= `SWS_FILL_BYTE;
							end
						end
						sws_pkg::FR_CAR_DATA: begin
							sample_idx_reg <= sample_idx_reg + 5'h01;
							if (sample_idx_reg == CAR_LAST) begin // [R11] [R13]
								frame_reg <= sws_pkg::FR_CRC_LO;
							end else begin
								tx_byte_reg <= port_pins;
							end
						end
						sws_pkg::FR_CAW_A: begin
							first_reg <= rx_full;
							frame_reg <= sws_pkg::FR_CAW_B;
						end
						sws_pkg::FR_CAW_B: begin
							if (rx_full == ~first_reg) begin
								port_state_reg <= first_reg; // [R17]
								frame_reg <= sws_pkg::FR_CAW_ACK;
								tx_byte_reg <= `SWS_CONFIRM_BYTE; // [R18]
							end else begin
								frame_reg <= sws_pkg::FR_FILL_FF; // [R19]
								tx_byte_reg <= `SWS_FILL_BYTE;
							end
						end
						sws_pkg::FR_CAW_ACK: begin
							// pins sampled after the new state has been applied
							frame_reg <= sws_pkg::FR_CAW_RB;
							tx_byte_reg <= port_pins; // [R18]
						end
						sws_pkg::FR_CAW_RB: frame_reg <= sws_pkg::FR_CAW_A;
						sws_pkg::FR_CS_DATA: begin
							cs_wr_strobe_reg <= 1'b1;
							cs_wr_addr_reg <= addr_reg[7:0];
							cs_wr_data_reg <= rx_full;
							if (addr_reg == `SWS_CS_LAST) begin
								frame_reg <= sws_pkg::FR_FILL_FF; // [R15]
								tx_byte_reg <= `SWS_FILL_BYTE;
							end else begin
								addr_reg <= addr_reg + 16'h0001;
							end
						end
						sws_pkg::FR_FILL_FF: frame_reg <= sws_pkg::FR_FILL_FF;
						sws_pkg::FR_FILL_AA: frame_reg <= sws_pkg::FR_FILL_AA;
					endcase
				end
			end
		end
	end

endmodule

// >>> sim/sws_slave_checker.sv
/*
 Port checker for sws_slave, bound into every instance.
 Assumes line_in is the resolved level of the line.
*/
`timescale 1ns/1ps
`include "sws_regs.svh"
module sws_slave_checker #(
	parameter int HOLD_STD_CYC = 300,
	parameter int HOLD_OD_CYC = 12,
	parameter int RST_LONG_CYC = 2000,
	parameter int RST_OD_CYC = 500
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic line_in,
	input wire logic line_oe,
	input wire logic set_fast,
	input wire logic fast_speed_flag,
	input wire logic latch_clear,
	input wire logic session_start,
	input wire logic [63:0] rom_code
);
	// std slots lose the start filter from the answer pulse
	localparam int FILT_C = (`SWS_FILTER_STD_NS + `SWS_CLK_PERIOD_NS - 1) / `SWS_CLK_PERIOD_NS;
	logic [16:0] oe_n, low_n, run_n;
	logic [9:0] gap_n;
	logic [1:0] rdy;
	int hold_c;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	assign hold_c = fast_speed_flag ? HOLD_OD_CYC : HOLD_STD_CYC;
	function automatic logic [7:0] crc8(input logic [55:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < 56; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ 8'h8C : c >> 1;
		return c;
	endfunction
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			oe_n <= 17'h0;
			low_n <= 17'h0;
			run_n <= 17'h0;
			gap_n <= 10'h3FF;
			rdy <= 2'h0;
		end else begin
			oe_n <= line_oe ? oe_n + 17'h1 : 17'h0;
			low_n <= line_in ? 17'h0 : low_n + 17'h1;
			run_n <= (line_in && low_n != 17'h0) ? low_n : run_n;
			// saturate so a long idle never wraps into a short gap
			gap_n <= line_oe ? 10'h0 : (gap_n == 10'h3FF ? gap_n : gap_n + 10'h1);
			rdy <= rdy == 2'h3 ? rdy : rdy + 2'h1;
		end
	end
	oe_len_a: assert property ($fell(line_oe) |->
		oe_n <= hold_c && oe_n + 6 + (fast_speed_flag ? 0 : FILT_C) >= hold_c)
		else $error("zero answer pulse has wrong width");
	oe_start_a: assert property ($rose(line_oe) |->
		!$past(line_in) || !$past(line_in, 2))
		else $error("line pulled low without a slot start");
	holdoff_gap_a: assert property ($rose(line_oe) |-> gap_n >= 100)
		else $error("slot accepted inside holdoff");
	fast_set_a: assert property ($rose(fast_speed_flag) |->
		$past(set_fast) || $past(set_fast, 2))
		else $error("fast speed entered without request");
	fast_clear_a: assert property ($fell(fast_speed_flag) |-> run_n >= RST_LONG_CYC)
		else $error("fast speed left after a short reset");
	session_len_a: assert property (session_start |->
		run_n >= (fast_speed_flag ? RST_OD_CYC : RST_LONG_CYC))
		else $error("session started after too short a reset");
	rom_crc_a: assert property (rdy == 2'h3 |->
		rom_code[63:56] == crc8(rom_code[55:0]))
		else $error("identifier check byte wrong");
	latch_pulse_a: assert property (latch_clear |=> !latch_clear)
		else $error("latch clear pulse too long");
	cover property ($rose(line_oe));
	cover property (latch_clear);
	cover property ($fell(fast_speed_flag));
endmodule
bind sws_slave sws_slave_checker #(
	.HOLD_STD_CYC(HOLD_STD_CYC),
	.HOLD_OD_CYC(HOLD_OD_CYC),
	.RST_LONG_CYC(RST_LONG_CYC),
	.RST_OD_CYC(RST_OD_CYC)
) i_sws_slave_checker (
	.sys_clk(sys_clk),
	.nrst(nrst),
	.line_in(line_in),
	.line_oe(line_oe),
	.set_fast(set_fast),
	.fast_speed_flag(fast_speed_flag),
	.latch_clear(latch_clear),
	.session_start(session_start),
	.rom_code(rom_code)
);

// >>> sim/sws_master_model.sv
/*
 Bus master model: resets, bit slots, glitches on the single line.
 Assumes a pull-up; drive_low high pulls the line down.
*/
`timescale 1ns/1ps
module sws_master_model (
	input wire logic sys_clk,
	input wire logic line_in,
	output logic drive_low
);
	logic fast = 1'b0;
	initial drive_low = 1'b0;
	task automatic tick(input logic v);
		@(posedge sys_clk);
		#1 drive_low = v;
	endtask
	task automatic bus_reset(input int n);
		for (int i = 0; i < n; i++) tick(1'b1);
		for (int i = 0; i < 450; i++) tick(1'b0);
	endtask
	// g adds a short low at ticks 40 to 59, inside the holdoff only after a fast slot
	task automatic slot(input logic b, input logic g, output logic r);
		int lo;
		int smp;
		int len;
		lo = b ? (fast ? 2 : 60) : (fast ? 16 : 316);
		smp = fast ? 8 : 200;
		len = fast ? 120 : 730;
		r = 1'b1;
		for (int t = 0; t < len; t++) begin
			if (t == smp) r = line_in;
			tick(t < lo || (g && t >= 40 && t < 60));
		end
	endtask
	task automatic put(input logic [7:0] d, input logic g);
		logic r;
		for (int i = 0; i < 8; i++) slot(d[i], g, r);
	endtask
	task automatic get(output logic [7:0] d);
		for (int i = 0; i < 8; i++) slot(1'b1, 1'b0, d[i]);
	endtask
	task automatic glitch(input int w);
		for (int i = 0; i < w + 450; i++) tick(i < w);
	endtask
endmodule

// >>> sim/testbench.sv
/*
 Self-checking bench of sws_slave driven by the master model.
 Assumes shortened slot and reset counts.
*/
`timescale 1ns/1ps
module testbench;
	localparam logic [7:0] C_RR = 8'h01, C_CR = 8'h02, C_CW = 8'h03, C_CS = 8'h04, C_LC = 8'h05;
	// shortened slot and reset counts keep the run short
	localparam int T_STD = 300, T_OD = 12, T_LONG = 2000, T_SHORT = 500;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic set_fast = 1'b0;
	logic [7:0] port_pins = 8'h5C;
	logic [63:0] reg_page;
	logic m_low;
	wire logic line_in;
	logic line_out, line_oe, fast_speed_flag, latch_clear, cs_wr_strobe, session_start;
	logic [7:0] port_state, cs_wr_addr, cs_wr_data;
	logic [63:0] rom_code;
	logic [15:0] cs_last = 16'h0000;
	int err_total = 0, cmp_count = 0, ss_n = 0, lc_n = 0, cs_n = 0;
	assign line_in = !(m_low || (line_oe && !line_out));
	always #2.5 sys_clk = ~sys_clk;
	sws_slave #(.SAMP_STD_CYC(T_STD), .HOLD_STD_CYC(T_STD), .SAMP_OD_CYC(T_OD),
		.HOLD_OD_CYC(T_OD), .RST_LONG_CYC(T_LONG), .RST_OD_CYC(T_SHORT)) i_sws_slave (
		.sys_clk(sys_clk), .nrst(nrst), .line_in(line_in), .line_out(line_out),
		.line_oe(line_oe), .set_fast(set_fast), .port_pins(port_pins), .reg_page(reg_page),
		.fast_speed_flag(fast_speed_flag), .port_state(port_state), .latch_clear(latch_clear),
		.cs_wr_strobe(cs_wr_strobe), .cs_wr_addr(cs_wr_addr), .cs_wr_data(cs_wr_data),
		.session_start(session_start), .rom_code(rom_code));
	sws_master_model i_sws_master_model (.sys_clk(sys_clk), .line_in(line_in), .drive_low(m_low));
	always @(posedge sys_clk) begin
		if (session_start === 1'b1) ss_n++;
		if (latch_clear === 1'b1) lc_n++;
		if (cs_wr_strobe === 1'b1) begin
			cs_n++;
			cs_last = {cs_wr_addr, cs_wr_data};
		end
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("errors %0d comparisons %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] d);
		for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ 16'hA001 : c >> 1;
		return c;
	endfunction
	task automatic wr(input logic [7:0] d);
		i_sws_master_model.put(d, 1'b0);
	endtask
	task automatic rx(input logic [7:0] e);
		logic [7:0] d;
		i_sws_master_model.get(d);
		check(d, e);
	endtask
	task automatic line_rst(input int n);
		int s;
		s = ss_n;
		i_sws_master_model.bus_reset(n);
		check(ss_n - s, 1);
		check(fast_speed_flag, n < T_LONG ? i_sws_master_model.fast : 1'b0);
	endtask
	task automatic t_reg_read;
		logic [15:0] c;
		line_rst(600);
		reg_page = 64'h8877665544332211;
		wr(C_RR);
		wr(8'h8D);
		wr(8'h00);
		c = crc(crc(crc(16'h0000, C_RR), 8'h8D), 8'h00);
		for (int a = 5; a < 8; a++) begin
			rx(reg_page[a*8 +: 8]);
			c = crc(c, reg_page[a*8 +: 8]);
		end
		rx(~c[7:0]);
		rx(~c[15:8]);
		rx(8'hFF);
	endtask
	task automatic t_chan_write;
		line_rst(600);
		wr(C_CW);
		i_sws_master_model.put(8'h3C, 1'b1);
		wr(8'hC3);
		check(port_state, 8'h3C);
		rx(8'hAA);
		rx(port_pins);
		wr(8'h55);
		wr(8'h55);
		check(port_state, 8'h3C);
		rx(8'hFF);
	endtask
	task automatic t_cs_write;
		int n;
		line_rst(600);
		n = cs_n;
		wr(C_CS);
		wr(8'h8D);
		wr(8'h00);
		wr(8'h77);
		check(cs_n - n, 1);
		check(cs_last, 16'h8D77);
		rx(8'hFF);
	endtask
	task automatic t_chan_read;
		logic [15:0] c;
		line_rst(600);
		wr(C_CR);
		c = crc(16'h0000, C_CR);
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 32; i++) begin
				rx(port_pins);
				c = crc(c, port_pins);
			end
			rx(~c[7:0]);
			port_pins = 8'hA3;
			rx(~c[15:8]);
			c = 16'h0000;
		end
	endtask
	task automatic t_std_latch;
		int n;
		line_rst(2100);
		i_sws_master_model.fast = 1'b0;
		n = lc_n;
		i_sws_master_model.glitch(30);
		wr(C_LC);
		check(lc_n - n, 1);
		rx(8'hAA);
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		#1 nrst = 1'b1;
		repeat (420) @(posedge sys_clk);
		line_rst(2100);
		@(posedge sys_clk) #1 set_fast = 1'b1;
		@(posedge sys_clk) #1 set_fast = 1'b0;
		i_sws_master_model.fast = 1'b1;
		t_reg_read();
		t_chan_write();
		t_cs_write();
		t_chan_read();
		t_std_latch();
		stop_test();
	end
endmodule
